// [design/regacc_pkg.sv]
`default_nettype none
package regacc_pkg;
  localparam int unsigned NUM_REGS = 64;
  localparam logic [5:0] CODE_WORD_REG = 6'h1F;
  localparam logic [5:0] FEATURE_REG = 6'h20;
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] RELOCK_CODE = 16'h0000;
  localparam int unsigned REG_MODE_BIT = 7;
  localparam int unsigned WRITE_BIT = 6;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // apb register offsets of the controller
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_PDATA = 8'h10;
  localparam int unsigned BUSY_BIT = 8;
  // edges the link command is held before the answer is taken
  localparam logic [1:0] LINK_WAIT = 2'h3;

  function automatic logic [7:0] make_ctrl(input logic wr,
                                           input logic [5:0] num);
    make_ctrl = {1'b1, wr, num};
  endfunction
endpackage
`default_nettype wire

// [design/pd_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pd_link_if;
  logic [7:0] control_byte;
  logic [15:0] output_data_word;
  logic [7:0] status_byte;
  logic [15:0] input_data_word;
  modport terminal (input control_byte, input output_data_word,
                    output status_byte, output input_data_word);
  modport controller (output control_byte, output output_data_word,
                      input status_byte, input input_data_word);
endinterface
`default_nettype wire

// [design/terminal_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module terminal_regs
  import regacc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  pd_link_if.terminal link,
  input wire logic [15:0] process_in,
  input wire logic [7:0] process_status,
  output logic [15:0] process_out,
  output logic [15:0] active_features
);
  // ************************************************************
  // register file and link sampling
  // ************************************************************
  logic [15:0] regs [NUM_REGS];
  logic [7:0] ctrl_q;
  logic [15:0] odata_q;
  logic unlocked;
  logic cfg_taken;
  logic is_reg, is_wr, wr_ok;
  logic [5:0] num;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= BYTE_RESET;
      odata_q <= REG_RESET;
    end else if (ce) begin
      ctrl_q <= link.control_byte;
      odata_q <= link.output_data_word;
    end
  end

  assign is_reg = ctrl_q[REG_MODE_BIT];
  assign is_wr = ctrl_q[WRITE_BIT];
  assign num = ctrl_q[5:0];
  assign wr_ok = unlocked || (num == CODE_WORD_REG);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (ce && is_reg && is_wr && wr_ok) begin
      regs[num] <= odata_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unlocked <= 1'b0;
    end else if (ce && is_reg && is_wr && num == CODE_WORD_REG) begin
      unlocked <= (odata_q == UNLOCK_CODE);
    end
  end

  // ************************************************************
  // answer path
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.status_byte <= BYTE_RESET;
      link.input_data_word <= REG_RESET;
      process_out <= REG_RESET;
    end else if (ce) begin
      if (is_reg && is_wr) begin
        link.status_byte <= {ctrl_q[7], 1'b0, ctrl_q[5:0]};
        link.input_data_word <= REG_RESET;
      end else if (is_reg) begin
        link.status_byte <= ctrl_q;
        link.input_data_word <= regs[num];
      end else begin
        link.status_byte <= process_status;
        link.input_data_word <= process_in;
        process_out <= odata_q;
      end
    end
  end

  // feature settings latch once after reset (power cycle)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_taken <= 1'b0;
      active_features <= REG_RESET;
    end else if (ce && !cfg_taken) begin
      cfg_taken <= 1'b1;
      active_features <= regs[FEATURE_REG];
    end
  end
endmodule
`default_nettype wire

// [design/controller_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module controller_regs
  import regacc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  pd_link_if.controller link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ************************************************************
  // apb slave
  // ************************************************************
  logic [15:0] wdata;
  logic [15:0] pdata;
  logic [7:0] stat;
  logic [15:0] rdata;
  logic busy;
  logic [1:0] wait_cnt;
  logic [7:0] cmd;
  logic start;
  logic acc;

  assign acc = psel && !penable;
  assign start = ce && psel && penable && pready && pwrite &&
                 paddr == OFS_CMD && !busy;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      pready <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        case (paddr)
          OFS_CMD: prdata <= {24'h000000, cmd};
          OFS_WDATA: prdata <= {16'h0000, wdata};
          OFS_STATUS: prdata <= {23'h000000, busy, stat};
          OFS_RDATA: prdata <= {16'h0000, rdata};
          OFS_PDATA: prdata <= {16'h0000, pdata};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdata <= REG_RESET;
      pdata <= REG_RESET;
      cmd <= BYTE_RESET;
    end else if (ce && psel && penable && pready && pwrite) begin
      if (paddr == OFS_WDATA) wdata <= pwdata[15:0];
      if (paddr == OFS_PDATA) pdata <= pwdata[15:0];
      if (start) cmd <= pwdata[7:0];
    end
  end

  // ************************************************************
  // link driver
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.control_byte <= BYTE_RESET;
      link.output_data_word <= REG_RESET;
      busy <= 1'b0;
      wait_cnt <= 2'h0;
      stat <= BYTE_RESET;
      rdata <= REG_RESET;
    end else if (ce) begin
      if (start) begin
        // normal mode keeps bit 7 clear
        link.control_byte <= pwdata[REG_MODE_BIT] ?
          make_ctrl(pwdata[WRITE_BIT], pwdata[5:0]) : pwdata[7:0];
        link.output_data_word <= (pwdata[REG_MODE_BIT] && pwdata[WRITE_BIT]) ?
          wdata : pdata;
        busy <= 1'b1;
        wait_cnt <= LINK_WAIT;
      end else if (busy) begin
        if (wait_cnt != 2'h0) begin
          wait_cnt <= wait_cnt - 2'h1;
        end else begin
          busy <= 1'b0;
          stat <= link.status_byte;
          if (!link.control_byte[WRITE_BIT]) begin
            rdata <= link.input_data_word;
          end
          link.control_byte <= BYTE_RESET;
          link.output_data_word <= pdata;
        end
      end else begin
        link.output_data_word <= pdata;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/regacc_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// link checker
// ****
module regacc_sva
  import regacc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] control_byte,
  input wire logic [15:0] output_data_word,
  input wire logic [7:0] status_byte,
  input wire logic [15:0] input_data_word
);
  logic [15:0] shadow [64];
  logic unlocked;
  wire logic [7:0] cb = control_byte;
  wire logic [7:0] sb = status_byte;
  wire logic [15:0] iw = input_data_word;
  wire logic [5:0] num = cb[5:0];
  wire logic [15:0] ex = shadow[num];
  wire logic rd = cb[7:6] == 2'b10;
  wire logic wr = cb[7:6] == 2'b11;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 64; i++)
        shadow[i] <= REG_RESET;
    end else if (wr && (unlocked || num == CODE_WORD_REG)) begin
      shadow[num] <= output_data_word;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      unlocked <= 1'b0;
    else if (wr && num == CODE_WORD_REG)
      unlocked <= output_data_word == UNLOCK_CODE;
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_twice;
    rd ##1 (rd && $stable(cb));
  endsequence
  AST_RD_ECHO: assert property (rd |-> ##2 sb == $past(cb, 2))
    else $error("read echo wrong");
  AST_WR_ACK: assert property (wr |-> ##2 sb == {2'b10, $past(num, 2)})
    else $error("write ack wrong");
  AST_WR_DATA: assert property (wr |-> ##2 iw == 16'h0000)
    else $error("write data word not cleared");
  AST_LOCKED: assert property (rd && !unlocked |-> ##2 iw == $past(ex, 2))
    else $error("locked read data wrong");
  AST_OPEN: assert property (rd && unlocked |-> ##2 iw == $past(ex, 2))
    else $error("unlocked read data wrong");
  AST_CODE: assert property (rd && num == CODE_WORD_REG |-> ##2 iw == $past(ex, 2))
    else $error("code word read wrong");
  AST_FEAT: assert property (rd && num == FEATURE_REG |-> ##2 iw == $past(ex, 2))
    else $error("feature read wrong");
  AST_STABLE: assert property (s_twice |-> ##2 $stable(iw))
    else $error("read changed register");
endmodule
`default_nettype wire

// [verification/register_access_with_write_lock_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch %0t got %h want %h", $time, a, b); end end
// ****
// bench
// ****
module register_access_with_write_lock_tb
  import regacc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, open = 1'b0;
  logic [7:0] paddr = 8'h00, pst = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [15:0] pin = 16'h0000, mdl [64];
  logic [15:0] po, af;
  int checks = 0, n_mismatch = 0, cyc = 0, seed = 92;
  pd_link_if link ();
  terminal_regs terminal_regs_i (.clk(clk), .arst_n(arst_n), .ce(1'b1),
    .link(link), .process_in(pin), .process_status(pst),
    .process_out(po), .active_features(af));
  controller_regs controller_regs_i (.clk(clk), .arst_n(arst_n),
    .ce(1'b1), .link(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  regacc_sva regacc_sva_i (.clk(clk), .arst_n(arst_n),
    .control_byte(link.control_byte),
    .output_data_word(link.output_data_word),
    .status_byte(link.status_byte), .input_data_word(link.input_data_word));
  always #10 clk = ~clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input logic m, input logic w, input logic [5:0] n,
                     input logic [15:0] v);
    apb(1'b1, (m && w) ? OFS_WDATA : OFS_PDATA, {16'h0000, v});
    apb(1'b1, OFS_CMD, {24'h000000, m, w, n});
    rd = 32'h00000100;
    for (int i = 0; i < 40 && rd[8] !== 1'b0; i++)
      apb(1'b0, OFS_STATUS, 32'h00000000);
    `CHK(rd[8], 1'b0)
    `CHK(rd[7:0], m ? {2'b10, n} : pst)
    if (m && !w) begin
      apb(1'b0, OFS_RDATA, 32'h00000000);
      `CHK(rd[15:0], mdl[n])
    end
    if (m && w && (open || n == CODE_WORD_REG))
      mdl[n] = v;
    if (m && w && n == CODE_WORD_REG)
      open = v == UNLOCK_CODE;
  endtask
  initial begin
    foreach (mdl[i])
      mdl[i] = 16'h0000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    run(1'b1, 1'b1, 6'h05, 16'hA5A5);
    run(1'b1, 1'b0, 6'h05, 16'h5A5A);
    run(1'b1, 1'b1, 6'h1F, 16'h1235);
    run(1'b1, 1'b0, 6'h1F, 16'hFFFF);
    run(1'b1, 1'b1, 6'h20, 16'h0002);
    run(1'b1, 1'b0, 6'h20, 16'h0000);
    `CHK(af, 16'h0000)
    for (int i = 0; i < 40; i++)
      run(1'b1, 1'($random(seed)), 6'($random(seed)), 16'($random(seed)));
    run(1'b1, 1'b1, 6'h1F, 16'h0000);
    run(1'b1, 1'b1, 6'h07, 16'hFFFF);
    run(1'b1, 1'b0, 6'h07, 16'h0000);
    pst <= 8'($random(seed)) & 8'h7F;
    pin <= 16'($random(seed));
    run(1'b0, 1'b0, 6'h00, 16'h3C3C);
    `CHK(po, 16'h3C3C)
    apb(1'b0, OFS_RDATA, 32'h00000000);
    `CHK(rd[15:0], pin)
    apb(1'b0, OFS_PDATA, 32'h00000000);
    `CHK(rd, 32'h00003C3C)
    apb(1'b0, OFS_WDATA, 32'h00000000);
    `CHK(rd, 32'h0000FFFF)
    apb(1'b0, OFS_CMD, 32'h00000000);
    `CHK(rd, 32'h00000000)
    `CHK(af, 16'h0000)
    apb(1'b0, 8'hFC, 32'h00000000);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h00000000)
    test_done();
  end
endmodule
`default_nettype wire
